// ==== phy_lp_pkg.sv ====
package phy_lp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  typedef logic [11:0] reg_addr_t;
  typedef logic [31:0] reg_word_t;

  localparam reg_addr_t HCC_SET_OFFSET = 12'h050;
  localparam reg_addr_t HCC_CLR_OFFSET = 12'h054;
  localparam int        REQ_BIT        = 19;
  localparam int        PHY_ACTIVE_BIT = 18;
  localparam reg_word_t HCC_RESET      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Cable detector pins
  // ----------------------------------------------------------------
  localparam int PIN_COUNT   = 2;
  localparam int PIN_CONNECT = 0;
  localparam int PIN_BIAS    = 1;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_LOW    = 2'b01,
    ST_ULTRA  = 2'b10,
    ST_WAKE   = 2'b11
  } lp_state_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int WAKE_TIME_US    = 2000;
  localparam int CLK_FREQ_KHZ    = 10000;
  // Request decode and retiming eat two edges of the window
  localparam int WAKE_PIPE       = 2;
  // Longest time: integer division rounds down
  localparam int WAKE_CYCLES_MAX = WAKE_TIME_US * CLK_FREQ_KHZ / 1000 -
                                   WAKE_PIPE;
  localparam int WAKE_CNT_W      = 15;
  typedef logic [WAKE_CNT_W-1:0] wake_cnt_t;

endpackage : phy_lp_pkg

// ==== port_event_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface port_event_if;
  logic connected;
  logic bias;
  logic connect_rise;
  logic disconnect_fall;
  logic bias_rise;

  modport src (
    output connected,
    output bias,
    output connect_rise,
    output disconnect_fall,
    output bias_rise
  );

  modport dst (
    input connected,
    input bias,
    input connect_rise,
    input disconnect_fall,
    input bias_rise
  );
endinterface : port_event_if
`default_nettype wire

// ==== pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input  wire logic   clock,
  input  wire logic   rst_n,
  input  wire logic   clk_en,
  input  wire logic   cable_connect_pin,
  input  wire logic   cable_bias_pin,
  port_event_if.src   ev
);
  import phy_lp_pkg::*;

  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] s1_reg;
  logic [PIN_COUNT-1:0] s2_reg;
  logic [PIN_COUNT-1:0] s3_reg;
  logic [PIN_COUNT-1:0] level_reg;
  logic [PIN_COUNT-1:0] rise_reg;
  logic [PIN_COUNT-1:0] fall_reg;

  assign pins[PIN_CONNECT] = cable_connect_pin;
  assign pins[PIN_BIAS]    = cable_bias_pin;

  // ----------------------------------------------------------------
  // Three-stage sync, level moves only when stages two and three agree
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_pin
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg[i] <= 1'b0;
          s2_reg[i] <= 1'b0;
          s3_reg[i] <= 1'b0;
        end else if (clk_en) begin
          s1_reg[i] <= pins[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
        end
      end

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          level_reg[i] <= 1'b0;
          rise_reg[i]  <= 1'b0;
          fall_reg[i]  <= 1'b0;
        end else if (clk_en) begin
          rise_reg[i] <= 1'b0;
          fall_reg[i] <= 1'b0;
          if (s2_reg[i] == s3_reg[i] && s3_reg[i] != level_reg[i]) begin
            level_reg[i] <= s3_reg[i];
            rise_reg[i]  <= s3_reg[i];
            fall_reg[i]  <= ~s3_reg[i];
          end
        end
      end
    end
  endgenerate

  assign ev.connected       = level_reg[PIN_CONNECT];
  assign ev.bias            = level_reg[PIN_BIAS];
  assign ev.connect_rise    = rise_reg[PIN_CONNECT];
  assign ev.disconnect_fall = fall_reg[PIN_CONNECT];
  assign ev.bias_rise       = rise_reg[PIN_BIAS];

endmodule : pin_sync
`default_nettype wire

// ==== phy_low_power_wake_control.sv ====
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Reduced host power, idle port: sleep automatically
// - Sleep gates clocks, references; detection stays outside ultralow
// - Ultralow only disconnected/disabled, interrupts off
// - Link power request bit set wakes device
// - Relevant port events also wake device
// - Clock valid within two milliseconds of wake
// - Awake PHY clocks the integrated link layer
module phy_low_power_wake_control #(
  parameter phy_lp_pkg::wake_cnt_t WAKE_CYCLES =
    phy_lp_pkg::wake_cnt_t'(phy_lp_pkg::WAKE_CYCLES_MAX)
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire phy_lp_pkg::reg_addr_t reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire phy_lp_pkg::reg_word_t reg_wdata,
  output var  phy_lp_pkg::reg_word_t reg_rdata,
  input  wire logic                  host_power_reduced,
  input  wire logic                  port_disabled,
  input  wire logic                  port_suspended,
  input  wire logic                  port_int_enable,
  input  wire logic                  cable_connect_pin,
  input  wire logic                  cable_bias_pin,
  output var  phy_lp_pkg::lp_state_t power_state,
  output var  logic                  clk_gen_enable,
  output var  logic                  ref_enable,
  output var  logic                  event_detect_enable,
  output var  logic                  link_clock_enable,
  output var  logic                  phy_clock_valid,
  output var  logic                  wake_pulse
);
  import phy_lp_pkg::*;

  port_event_if ev ();

  lp_state_t state_reg;
  lp_state_t state_next;
  wake_cnt_t wake_cnt_reg;
  logic      link_power_request_bit;
  logic      req_phy_reg;
  logic      int_en_phy_reg;
  logic      port_idle;
  logic      sleep_ok;
  logic      ultra_ok;
  logic      port_wake;
  reg_word_t hcc_view;

  function automatic logic is_sleep(input lp_state_t s);
    return (s == ST_LOW) || (s == ST_ULTRA);
  endfunction : is_sleep

  pin_sync u_pin_sync (
    .clock             (clock),
    .rst_n             (rst_n),
    .clk_en            (clk_en),
    .cable_connect_pin (cable_connect_pin),
    .cable_bias_pin    (cable_bias_pin),
    .ev                (ev)
  );

  // ----------------------------------------------------------------
  // Host controller control, set and clear views
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_power_request_bit <= HCC_RESET[REQ_BIT];
    end else if (clk_en && reg_wr && reg_wdata[REQ_BIT]) begin
      if (reg_addr == HCC_SET_OFFSET) begin
        link_power_request_bit <= 1'b1;
      end else if (reg_addr == HCC_CLR_OFFSET) begin
        link_power_request_bit <= 1'b0;
      end
    end
  end

  always_comb begin
    hcc_view                 = HCC_RESET;
    hcc_view[REQ_BIT]        = link_power_request_bit;
    hcc_view[PHY_ACTIVE_BIT] = (state_reg == ST_ACTIVE);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= HCC_RESET;
    end else if (clk_en && reg_rd) begin
      if (reg_addr == HCC_SET_OFFSET || reg_addr == HCC_CLR_OFFSET) begin
        reg_rdata <= hcc_view;
      end else begin
        reg_rdata <= HCC_RESET;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control retiming into the PHY side
  // ----------------------------------------------------------------
  // One stage keeps register decode off the sleep decision path
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_phy_reg    <= 1'b0;
      int_en_phy_reg <= 1'b0;
    end else if (clk_en) begin
      req_phy_reg    <= link_power_request_bit;
      int_en_phy_reg <= port_int_enable;
    end
  end

  // ----------------------------------------------------------------
  // Sleep and wake decisions
  // ----------------------------------------------------------------
  assign port_idle = !ev.connected || port_disabled || port_suspended;
  assign sleep_ok  = host_power_reduced && port_idle && !req_phy_reg;
  assign ultra_ok  = (!ev.connected || port_disabled) &&
                     !int_en_phy_reg;
  assign port_wake = (ev.bias_rise && port_suspended) ||
                     (ev.disconnect_fall && port_suspended) ||
                     (ev.connect_rise && !port_disabled);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_ACTIVE: begin
        if (sleep_ok) begin
          state_next = ultra_ok ? ST_ULTRA : ST_LOW;
        end
      end
      ST_LOW, ST_ULTRA: begin
        if (req_phy_reg || port_wake) begin
          state_next = ST_WAKE;
        end else begin
          state_next = ultra_ok ? ST_ULTRA : ST_LOW;
        end
      end
      ST_WAKE: begin
        if (wake_cnt_reg >= WAKE_CYCLES - wake_cnt_t'(1)) begin
          state_next = ST_ACTIVE;
        end
      end
    endcase
  end

  // Reset starts the clock restart path so the PHY comes up by itself
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_WAKE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == ST_WAKE) begin
        wake_cnt_reg <= wake_cnt_reg + wake_cnt_t'(1);
      end else begin
        wake_cnt_reg <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power controls, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_state         <= ST_WAKE;
      clk_gen_enable      <= 1'b1;
      ref_enable          <= 1'b1;
      event_detect_enable <= 1'b1;
      link_clock_enable   <= 1'b0;
      phy_clock_valid     <= 1'b0;
      wake_pulse          <= 1'b0;
    end else if (clk_en) begin
      power_state         <= state_next;
      clk_gen_enable      <= !is_sleep(state_next);
      ref_enable          <= !is_sleep(state_next);
      // Connect detection stays on in low sleep, goes off in ultralow
      event_detect_enable <= (state_next != ST_ULTRA);
      link_clock_enable   <= (state_next == ST_ACTIVE);
      phy_clock_valid     <= (state_next == ST_ACTIVE);
      wake_pulse          <= is_sleep(state_reg) &&
                             (state_next == ST_WAKE);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_auto_entry;
    (state_reg == ST_ACTIVE && sleep_ok && clk_en) |=>
      is_sleep(state_reg) && !link_clock_enable;
  endproperty
  a_auto_entry: assert property (p_auto_entry)
    else $error("no automatic sleep entry");

  property p_sleep_gated;
    is_sleep(state_reg) |-> !clk_gen_enable && !ref_enable &&
      (event_detect_enable == (state_reg == ST_LOW));
  endproperty
  a_sleep_gated: assert property (p_sleep_gated)
    else $error("clock or references left on in sleep");

  property p_ultra_cause;
    (clk_en && state_next == ST_ULTRA) |->
      !int_en_phy_reg && (!ev.connected || port_disabled);
  endproperty
  a_ultra_cause: assert property (p_ultra_cause)
    else $error("ultralow entered without cause");

  property p_req_wake;
    (is_sleep(state_reg) && req_phy_reg && clk_en) |=>
      state_reg == ST_WAKE && wake_pulse && clk_gen_enable;
  endproperty
  a_req_wake: assert property (p_req_wake)
    else $error("request bit did not wake");

  property p_event_wake;
    (is_sleep(state_reg) && port_wake && clk_en) |=>
      state_reg == ST_WAKE;
  endproperty
  a_event_wake: assert property (p_event_wake)
    else $error("port event did not wake");

  property p_wake_bound;
    (state_reg == ST_WAKE) |-> wake_cnt_reg < WAKE_CYCLES;
  endproperty
  a_wake_bound: assert property (p_wake_bound)
    else $error("wake exceeded its window");

  property p_link_clock;
    link_clock_enable |-> phy_clock_valid && clk_gen_enable &&
      power_state == ST_ACTIVE;
  endproperty
  a_link_clock: assert property (p_link_clock)
    else $error("link clock without running PHY clock");

  property p_valid_status;
    $rose(phy_clock_valid) |-> $past(state_reg) == ST_WAKE &&
      state_reg == ST_ACTIVE;
  endproperty
  a_valid_status: assert property (p_valid_status)
    else $error("clock valid rose outside wake");

endmodule : phy_low_power_wake_control
`default_nettype wire

// ==== cable_peer.sv ====
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Remote cable end
// ------------------------------
module cable_peer (
  input  wire logic plug,
  input  wire logic bias_on,
  output var  logic cable_connect_pin,
  output var  logic cable_bias_pin
);
  initial begin
    cable_connect_pin = 1'b0;
    cable_bias_pin = 1'b0;
  end
  // Off the clock grid, like a real cable
  always @(plug) cable_connect_pin <= #37 plug;
  // Bias only through a plugged cable
  always @(plug, bias_on) cable_bias_pin <= #53 (plug & bias_on);
endmodule : cable_peer
`default_nettype wire

// ==== phy_low_power_wake_control_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module phy_low_power_wake_control_bench;
  import phy_lp_pkg::*;
  // ------------------------------
  // Signals
  // ------------------------------
  logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, en = 1;
  logic hpr = 0, dis = 0, susp = 0, int_en = 0, plug = 0, bias_on = 0;
  logic con_pin, bias_pin, clk_gen, ref_en, ev_en, link_clk, valid, wake;
  reg_addr_t addr = '0;
  reg_word_t wdata = '0, rdata;
  lp_state_t state;
  reg_word_t rd_q[$];
  logic wake_q[$];
  logic rd_due = 0;
  int num_errors = 0, n_compared = 0, cyc = 0, seed = 32'h6ca7;
  localparam wake_cnt_t WC = 15'h0008;
  localparam reg_word_t RQ = 32'h0008_0000, ACT = 32'h0004_0000;

  initial forever #50 clock = ~clock;

  cable_peer peer (.plug(plug), .bias_on(bias_on),
    .cable_connect_pin(con_pin), .cable_bias_pin(bias_pin));

  phy_low_power_wake_control #(.WAKE_CYCLES(WC)) DUT (
    .clock(clock), .rst_n(rst_n), .clk_en(en), .reg_addr(addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(wdata),
    .reg_rdata(rdata), .host_power_reduced(hpr), .port_disabled(dis),
    .port_suspended(susp), .port_int_enable(int_en),
    .cable_connect_pin(con_pin), .cable_bias_pin(bias_pin),
    .power_state(state), .clk_gen_enable(clk_gen), .ref_enable(ref_en),
    .event_detect_enable(ev_en), .link_clock_enable(link_clk),
    .phy_clock_valid(valid), .wake_pulse(wake));

  // ------------------------------
  // Checks and report
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic results();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // Watcher: one note taken per result seen
  always @(posedge clock) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      results();
    end else begin
      if (rd_due) begin
        if (rd_q.size() == 0) chk("read note", 1, 0);
        else chk("reg_rdata", rd_q.pop_front(), rdata);
      end
      rd_due <= reg_rd;
      if (wake === 1'b1) begin
        if (wake_q.size() == 0) chk("unexpected wake", 0, 1);
        else void'(wake_q.pop_front());
      end
    end
  end

  // ------------------------------
  // Drivers
  // ------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic wr(input reg_addr_t a, input reg_word_t d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input reg_addr_t a, input reg_word_t e);
    rd_q.push_back(e);
    @(posedge clock);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask : rd

  // Bounded wait for the PHY clock to come back
  task automatic wait_valid(input int n);
    for (int i = 0; i < n && valid !== 1'b1; i++) @(posedge clock);
    chk("phy_clock_valid", 1, valid);
    chk("link_clock_enable", 1, link_clk);
  endtask : wait_valid

  task automatic sleep_chk(input lp_state_t s);
    tick(6);
    chk("power_state", s, state);
    chk("clk_gen_enable", 0, clk_gen);
    chk("event_detect_enable", s == ST_LOW, ev_en);
    chk("phy_clock_valid", 0, valid);
  endtask : sleep_chk

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    tick(2);
    rst_n <= 1'b1;
    wait_valid(WC + 4);
    chk("power_state", ST_ACTIVE, state);
    rd(HCC_SET_OFFSET, ACT);
    rd(12'h058, 32'h0000_0000);
    hpr <= 1'b1;
    sleep_chk(ST_ULTRA);
    chk("ref_enable", 0, ref_en);
    rd(HCC_SET_OFFSET, 32'h0000_0000);
    int_en <= 1'b1;
    sleep_chk(ST_LOW);
    wake_q.push_back(1);
    wr(HCC_SET_OFFSET, $random(seed) | RQ);
    wait_valid(WC + 5);
    wr(HCC_SET_OFFSET, $random(seed) & ~RQ);
    rd(HCC_CLR_OFFSET, RQ | ACT);
    wr(HCC_CLR_OFFSET, RQ);
    sleep_chk(ST_LOW);
    dis <= 1'b1;
    plug <= 1'b1;
    sleep_chk(ST_LOW);
    plug <= 1'b0;
    sleep_chk(ST_LOW);
    dis <= 1'b0;
    wake_q.push_back(1);
    plug <= 1'b1;
    wait_valid(WC + 12);
    susp <= 1'b1;
    sleep_chk(ST_LOW);
    wake_q.push_back(1);
    bias_on <= 1'b1;
    wait_valid(WC + 12);
    bias_on <= 1'b0;
    sleep_chk(ST_LOW);
    wake_q.push_back(1);
    plug <= 1'b0;
    wait_valid(WC + 12);
    int_en <= 1'b0;
    sleep_chk(ST_ULTRA);
    hpr <= 1'b0;
    sleep_chk(ST_ULTRA);
    en <= 1'b0;
    plug <= 1'b1;
    tick(10);
    chk("frozen power_state", ST_ULTRA, state);
    chk("frozen wake_pulse", 0, wake);
    en <= 1'b1;
    wake_q.push_back(1);
    wait_valid(WC + 12);
    tick(3);
    chk("wake notes left", 0, wake_q.size());
    results();
  end
endmodule : phy_low_power_wake_control_bench
`default_nettype wire
